// >>> src/occ_pkg.sv
// shared constants and types for the dual overcurrent comparator
package occ_pkg;

    localparam int RES_W   = 16;
    localparam int CNT_W   = 5;
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int NCH     = 2;
    localparam int DEC_OSR = 64;
    localparam int ACC_W   = 20;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF     = 8'h00;
    localparam logic [7:0] CFG_A_OFF    = 8'h04;
    localparam logic [7:0] UPPER_A_OFF  = 8'h08;
    localparam logic [7:0] LOWER_A_OFF  = 8'h0c;
    localparam logic [7:0] CFG_B_OFF    = 8'h10;
    localparam logic [7:0] UPPER_B_OFF  = 8'h14;
    localparam logic [7:0] LOWER_B_OFF  = 8'h18;
    localparam logic [7:0] DETAIL_OFF   = 8'h1c;
    localparam logic [7:0] MASK_OFF     = 8'h20;
    localparam logic [7:0] MAIN_OFF     = 8'h24;
    localparam logic [7:0] PINCFG_OFF   = 8'h28;
    localparam logic [7:0] RESULT_A_OFF = 8'h2c;
    localparam logic [7:0] RESULT_B_OFF = 8'h30;
    localparam logic [7:0] IRQ_ST_OFF   = 8'h34;
    localparam logic [7:0] IRQ_CLR_OFF  = 8'h38;
    localparam logic [7:0] IRQ_EN_OFF   = 8'h3c;

    // control field positions: enables at bit ch, adc enables at 2+ch
    localparam int CTRL_ADC_POS = 2;
    // pin config: per pin 4 bits starting at 4*ch
    localparam int PIN_DIR_POS  = 0;
    localparam int PIN_SRC_POS  = 1;
    localparam int PIN_FMT_POS  = 2;
    localparam int PIN_POL_POS  = 3;
    localparam int PIN_FLD_W    = 4;

    // reset values
    localparam logic [RES_W-1:0] UPPER_RST = 16'h7fff;
    localparam logic [RES_W-1:0] LOWER_RST = 16'h8000;
    localparam logic [CNT_W-1:0] COUNT_RST = 5'h00;
    localparam logic [1:0]       CTRL_RST  = 2'h0;
    localparam logic [1:0]       ADC_RST   = 2'h3;
    localparam logic [7:0]       PIN_RST   = 8'h00;

    // heartbeat half period on the trip pins
    localparam int PWM_HALF_NS = 50000;
    localparam int CLK_NS      = 50;
    localparam int PWM_HALF_CYC = PWM_HALF_NS / CLK_NS;

    typedef struct packed {
        logic [CNT_W-1:0] trip_count_setting;
        logic [RES_W-1:0] upper_limit;
        logic [RES_W-1:0] lower_limit;
    } cmp_cfg_type;

    typedef struct packed {
        logic dir;
        logic src;
        logic fmt;
        logic pol;
    } pin_cfg_type;

endpackage

// >>> src/fast_sinc3.sv
// sinc3 decimator, one modulator bit per enabled cycle
`timescale 1ns/1ps
`default_nettype none
module fast_sinc3
    import occ_pkg::*;
#(
    parameter int OSR = DEC_OSR
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             run,
    input  wire logic             mod_bit,
    output logic [RES_W-1:0]      result,
    output logic                  valid
);

    logic signed [ACC_W-1:0] i1_r, i2_r, i3_r, i1_nxt, i2_nxt, i3_nxt;
    logic signed [ACC_W-1:0] d1_r, d2_r, d3_r, d1_nxt, d2_nxt, d3_nxt;
    logic [$clog2(OSR)-1:0]  ph_r, ph_nxt;
    logic [RES_W-1:0]        res_r, res_nxt;
    logic                    vld_r, vld_nxt;
    logic signed [ACC_W-1:0] c1, c2, c3;

    always_comb begin
        i1_nxt  = i1_r;
        i2_nxt  = i2_r;
        i3_nxt  = i3_r;
        d1_nxt  = d1_r;
        d2_nxt  = d2_r;
        d3_nxt  = d3_r;
        ph_nxt  = ph_r;
        res_nxt = res_r;
        vld_nxt = 1'b0;
        c1 = i3_r - d1_r;
        c2 = c1 - d2_r;
        c3 = c2 - d3_r;
        if (!run) begin
            // held clear while off so each enable starts fresh
            i1_nxt = '0;
            i2_nxt = '0;
            i3_nxt = '0;
            d1_nxt = '0;
            d2_nxt = '0;
            d3_nxt = '0;
            ph_nxt = '0;
        end else begin
            i1_nxt = i1_r + (mod_bit ? ACC_W'(1) : -ACC_W'(1));
            i2_nxt = i2_r + i1_r;
            i3_nxt = i3_r + i2_r;
            ph_nxt = ph_r + 1'b1;
            if (ph_r == '1) begin
                d1_nxt  = i3_r;
                d2_nxt  = c1;
                d3_nxt  = c2;
                vld_nxt = 1'b1;
                // full scale +2^18 would wrap; clip to the top code
                if (c3[ACC_W-1:ACC_W-2] == 2'b01) begin
                    res_nxt = 16'h7fff;
                end else begin
                    res_nxt = c3[18:3];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            i1_r  <= '0;
            i2_r  <= '0;
            i3_r  <= '0;
            d1_r  <= '0;
            d2_r  <= '0;
            d3_r  <= '0;
            ph_r  <= '0;
            res_r <= '0;
            vld_r <= 1'b0;
        end else if (ce) begin
            i1_r  <= i1_nxt;
            i2_r  <= i2_nxt;
            i3_r  <= i3_nxt;
            d1_r  <= d1_nxt;
            d2_r  <= d2_nxt;
            d3_r  <= d3_nxt;
            ph_r  <= ph_nxt;
            res_r <= res_nxt;
            vld_r <= vld_nxt;
        end
    end

    assign result = res_r;
    assign valid  = vld_r & ce;

endmodule // fast_sinc3
`default_nettype wire

// >>> src/dual_overcurrent_comparator.sv
// two digital overcurrent comparators with trip flags, pins and registers
// Notes on behaviour
// (R1) each comparator has its own sinc3 decimator, ratio 64, beside main filter
// (R2) no offset or gain correction touches comparator results
// (R3) comparator needs its current adc enabled, not converting
// (R4) filter starts at enable, independent of conversion state
// (R5) 16-bit result above upper or below lower limit is a trip
// (R6) upper 7fff and lower 8000 never trip
// (R7) 5-bit count sets exceeding results needed; zero trips on one
// (R8) exceed counter clears on an inside result or on disable
// (R9) host disables a comparator before changing its settings
// (R10) detail flags active low; unmasked zero drives combined flag low
// (R11) combined flag clears only once all detail flags are cleared
// (R12) masked detail flag still records but leaves combined flag alone
// (R13) pin 3 shows comparator a with dir 1 and src 0; pin 4 b
// (R14) trip pin active while upper or lower flag is zero, mask ignored
// (R15) pin format and polarity bits shape active and idle waveform
// (R16) one-period trip on large overshoot, four on marginal
// (R17) limits and results compare as signed two's complement
// (R18) detail flags stay low until host writes one
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dual_overcurrent_comparator
    import occ_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic [NCH-1:0]    mod_bit,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [DATA_W-1:0]      rdata,
    output logic [NCH-1:0]         trip_pin_out,
    output logic [NCH-1:0]         trip_pin_oe_n,
    output logic                   combined_overcurrent_fault_n,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [NCH-1:0] mod_s1_r, mod_s2_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            mod_s1_r <= '0;
            mod_s2_r <= '0;
        end else if (ce) begin
            mod_s1_r <= mod_bit;
            mod_s2_r <= mod_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file

    cmp_cfg_type [NCH-1:0] cfg_r, cfg_nxt;
    logic [NCH-1:0]        comparator_enable_r, comparator_enable_nxt;
    logic [NCH-1:0]        current_adc_enable_r, current_adc_enable_nxt;
    logic [2*NCH-1:0]      overcurrent_fault_mask_r, overcurrent_fault_mask_nxt;
    logic [7:0]            pin_cfg_r, pin_cfg_nxt;
    logic [NCH-1:0]        irq_en_r, irq_en_nxt;
    logic [DATA_W-1:0]     rdata_r, rdata_nxt;

    // detail flags: {lower_b, upper_b, lower_a, upper_a}, active low
    logic [2*NCH-1:0]      detail_n_r, detail_n_nxt;
    logic                  comb_n_r, comb_n_nxt;
    logic [NCH-1:0]        irq_st_r, irq_st_nxt;

    logic [NCH-1:0]        run;
    logic [RES_W-1:0]      res [NCH];
    logic [NCH-1:0]        res_vld;
    logic [NCH-1:0]        set_upper, set_lower;
    logic [2*NCH-1:0]      detail_set;

    always_comb begin
        cfg_nxt                    = cfg_r;
        comparator_enable_nxt      = comparator_enable_r;
        current_adc_enable_nxt     = current_adc_enable_r;
        overcurrent_fault_mask_nxt = overcurrent_fault_mask_r;
        pin_cfg_nxt                = pin_cfg_r;
        irq_en_nxt                 = irq_en_r;
        rdata_nxt                  = '0;
        if (wr) begin
            case (addr)
                CTRL_OFF: begin
                    comparator_enable_nxt  = wdata[NCH-1:0];
                    current_adc_enable_nxt = wdata[CTRL_ADC_POS +: NCH];
                end
                // settings are taken as written; host keeps enable low (R9)
                CFG_A_OFF:   cfg_nxt[0].trip_count_setting = wdata[CNT_W-1:0];
                UPPER_A_OFF: cfg_nxt[0].upper_limit = wdata[RES_W-1:0];
                LOWER_A_OFF: cfg_nxt[0].lower_limit = wdata[RES_W-1:0];
                CFG_B_OFF:   cfg_nxt[1].trip_count_setting = wdata[CNT_W-1:0];
                UPPER_B_OFF: cfg_nxt[1].upper_limit = wdata[RES_W-1:0];
                LOWER_B_OFF: cfg_nxt[1].lower_limit = wdata[RES_W-1:0];
                MASK_OFF:    overcurrent_fault_mask_nxt = wdata[2*NCH-1:0];
                PINCFG_OFF:  pin_cfg_nxt = wdata[7:0];
                IRQ_EN_OFF:  irq_en_nxt = wdata[NCH-1:0];
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (addr)
                CTRL_OFF: begin
                    rdata_nxt[NCH-1:0]            = comparator_enable_r;
                    rdata_nxt[CTRL_ADC_POS +: NCH] = current_adc_enable_r;
                end
                CFG_A_OFF:    rdata_nxt[CNT_W-1:0] = cfg_r[0].trip_count_setting;
                UPPER_A_OFF:  rdata_nxt[RES_W-1:0] = cfg_r[0].upper_limit;
                LOWER_A_OFF:  rdata_nxt[RES_W-1:0] = cfg_r[0].lower_limit;
                CFG_B_OFF:    rdata_nxt[CNT_W-1:0] = cfg_r[1].trip_count_setting;
                UPPER_B_OFF:  rdata_nxt[RES_W-1:0] = cfg_r[1].upper_limit;
                LOWER_B_OFF:  rdata_nxt[RES_W-1:0] = cfg_r[1].lower_limit;
                DETAIL_OFF:   rdata_nxt[2*NCH-1:0] = detail_n_r;
                MASK_OFF:     rdata_nxt[2*NCH-1:0] = overcurrent_fault_mask_r;
                MAIN_OFF:     rdata_nxt[0] = comb_n_r;
                PINCFG_OFF:   rdata_nxt[7:0] = pin_cfg_r;
                // raw uncorrected values for software monitoring (R2)
                RESULT_A_OFF: rdata_nxt[RES_W-1:0] = res[0];
                RESULT_B_OFF: rdata_nxt[RES_W-1:0] = res[1];
                IRQ_ST_OFF:   rdata_nxt[NCH-1:0] = irq_st_r;
                IRQ_EN_OFF:   rdata_nxt[NCH-1:0] = irq_en_r;
                default:      rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                cfg_r[i].trip_count_setting <= COUNT_RST;
                cfg_r[i].upper_limit        <= UPPER_RST;
                cfg_r[i].lower_limit        <= LOWER_RST;
            end
            comparator_enable_r      <= CTRL_RST;
            current_adc_enable_r     <= ADC_RST;
            overcurrent_fault_mask_r <= '0;
            pin_cfg_r                <= PIN_RST;
            irq_en_r                 <= '0;
            rdata_r                  <= '0;
        end else if (ce) begin
            cfg_r                    <= cfg_nxt;
            comparator_enable_r      <= comparator_enable_nxt;
            current_adc_enable_r     <= current_adc_enable_nxt;
            overcurrent_fault_mask_r <= overcurrent_fault_mask_nxt;
            pin_cfg_r                <= pin_cfg_nxt;
            irq_en_r                 <= irq_en_nxt;
            rdata_r                  <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // per comparator: decimator, limit check, exceed counter

    generate
        for (genvar ch = 0; ch < NCH; ch++) begin : g_cmp
            logic [CNT_W-1:0]  cnt_r, cnt_nxt;
            logic              over, under;

            // modulator only runs with its adc on; conversions not needed
            assign run[ch] = comparator_enable_r[ch]
                           & current_adc_enable_r[ch]; // (R3) (R4)

            // dedicated decimator; raw output, no calibration stage (R1) (R2)
            fast_sinc3 #(
                .OSR     (DEC_OSR)
            ) u_sinc3 (
                .clk     (clk),
                .rst     (rst),
                .ce      (ce),
                .run     (run[ch]),
                .mod_bit (mod_s2_r[ch]),
                .result  (res[ch]),
                .valid   (res_vld[ch])
            ); // (R16)

            // strict compares, so 7fff and 8000 can never be passed (R6)
            assign over  = $signed(res[ch])
                         > $signed(cfg_r[ch].upper_limit); // (R5) (R17)
            assign under = $signed(res[ch])
                         < $signed(cfg_r[ch].lower_limit); // (R5) (R17)

            always_comb begin
                cnt_nxt = cnt_r;
                set_upper[ch] = 1'b0;
                set_lower[ch] = 1'b0;
                if (!comparator_enable_r[ch]) begin
                    cnt_nxt = '0; // (R8)
                end else if (res_vld[ch]) begin
                    if (over || under) begin
                        // count of earlier exceeds reaching setting trips (R7)
                        if (cnt_r >= cfg_r[ch].trip_count_setting) begin
                            set_upper[ch] = over;
                            set_lower[ch] = under;
                        end
                        if (cnt_r != '1) begin
                            cnt_nxt = cnt_r + 1'b1;
                        end
                    end else begin
                        cnt_nxt = '0; // (R8)
                    end
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    cnt_r <= '0;
                end else if (ce) begin
                    cnt_r <= cnt_nxt;
                end
            end

            assign detail_set[2*ch]   = set_upper[ch];
            assign detail_set[2*ch+1] = set_lower[ch];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // flags and interrupt

    logic [2*NCH-1:0] detail_clr;
    logic             comb_set;
    logic             comb_clr;
    logic [NCH-1:0]   irq_ev;

    always_comb begin
        detail_clr = '0;
        comb_clr   = 1'b0;
        if (wr && addr == DETAIL_OFF) begin
            detail_clr = wdata[2*NCH-1:0];
        end
        // clear refused while any detail flag still reads low (R11)
        if (wr && addr == MAIN_OFF && wdata[0] && (&detail_n_r)) begin
            comb_clr = 1'b1;
        end
        // set beats clear in the same cycle (R18)
        detail_n_nxt = (detail_n_r | detail_clr) & ~detail_set;
        // masked flags still latch above but do not reach here (R10) (R12)
        comb_set   = |(detail_set & ~overcurrent_fault_mask_r);
        comb_n_nxt = comb_n_r;
        if (comb_clr) begin
            comb_n_nxt = 1'b1;
        end
        if (comb_set) begin
            comb_n_nxt = 1'b0; // (R10)
        end
        for (int i = 0; i < NCH; i++) begin
            irq_ev[i] = set_upper[i] | set_lower[i];
        end
        irq_st_nxt = irq_st_r;
        if (wr && addr == IRQ_CLR_OFF) begin
            irq_st_nxt = irq_st_r & ~wdata[NCH-1:0];
        end
        irq_st_nxt = irq_st_nxt | irq_ev;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            detail_n_r <= '1;
            comb_n_r   <= 1'b1;
            irq_st_r   <= '0;
        end else if (ce) begin
            detail_n_r <= detail_n_nxt;
            comb_n_r   <= comb_n_nxt;
            irq_st_r   <= irq_st_nxt;
        end
    end

    assign combined_overcurrent_fault_n = comb_n_r;
    assign irq = |(irq_st_r & irq_en_r);

    ////////////////////////////////////////////////////////////////////////
    // trip pins

    localparam int PWM_W = $clog2(PWM_HALF_CYC + 1);
    logic [PWM_W-1:0] pwm_cnt_r, pwm_cnt_nxt;
    logic             pwm_r, pwm_nxt;
    logic [NCH-1:0]   pin_out_r, pin_out_nxt;
    logic [NCH-1:0]   pin_oe_n_r, pin_oe_n_nxt;
    pin_cfg_type      pc;
    logic             active;

    always_comb begin
        pwm_cnt_nxt = pwm_cnt_r + 1'b1;
        pwm_nxt     = pwm_r;
        if (pwm_cnt_r == PWM_W'(PWM_HALF_CYC - 1)) begin
            pwm_cnt_nxt = '0;
            pwm_nxt     = ~pwm_r;
        end
        pc     = '0;
        active = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            // fields picked by position, not by struct member order
            pc.dir = pin_cfg_r[PIN_FLD_W*i + PIN_DIR_POS];
            pc.src = pin_cfg_r[PIN_FLD_W*i + PIN_SRC_POS];
            pc.fmt = pin_cfg_r[PIN_FLD_W*i + PIN_FMT_POS];
            pc.pol = pin_cfg_r[PIN_FLD_W*i + PIN_POL_POS];
            // mask has no say on the pin (R14)
            active = ~(detail_n_r[2*i] & detail_n_r[2*i+1]); // (R14)
            // pin driven only as output with comparator source (R13)
            pin_oe_n_nxt[i] = ~(pc.dir & ~pc.src); // (R13)
            // active: static level; idle: static or heartbeat (R15)
            if (active) begin
                pin_out_nxt[i] = pc.pol;
            end else if (pc.fmt) begin
                pin_out_nxt[i] = pwm_r;
            end else begin
                pin_out_nxt[i] = ~pc.pol;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_cnt_r  <= '0;
            pwm_r      <= 1'b0;
            pin_out_r  <= '0;
            pin_oe_n_r <= '1;
        end else if (ce) begin
            pwm_cnt_r  <= pwm_cnt_nxt;
            pwm_r      <= pwm_nxt;
            pin_out_r  <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
        end
    end

    assign trip_pin_out  = pin_out_r;
    assign trip_pin_oe_n = pin_oe_n_r;

endmodule // dual_overcurrent_comparator
`default_nettype wire

// >>> verif/occ_checker_asserts.sv
// port-level checks for the dual overcurrent comparator
`timescale 1ns/1ps
`default_nettype none
module occ_checker
    import occ_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [NCH-1:0]    trip_pin_oe_n,
    input wire logic              combined_overcurrent_fault_n,
    input wire logic              irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire pin_wr = wr && addr == PINCFG_OFF;
    wire main_wr = wr && addr == MAIN_OFF && wdata[0];
    ////////////////////////////////////////////////////////////////////
    property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
    property p_unmapped; rd && addr == 8'h40 |=> rdata == 32'h0; endproperty
    property p_main_rd;
        rd && addr == MAIN_OFF |=>
            rdata == {31'h0, $past(combined_overcurrent_fault_n)};
    endproperty
    // the combined flag only returns high through a host clear
    property p_comb_rise;
        $rose(combined_overcurrent_fault_n) |-> $past(main_wr);
    endproperty
    property p_oe;
        !$stable(trip_pin_oe_n) |->
            $past(pin_wr) || $past(pin_wr, 2) || $past(pin_wr, 3);
    endproperty
    property p_ctrl_rb;
        wr && addr == CTRL_OFF ##2 rd && addr == CTRL_OFF |=>
            rdata[3:0] == $past(wdata[3:0], 3);
    endproperty
    property p_upper_rb;
        wr && addr == UPPER_A_OFF ##2 rd && addr == UPPER_A_OFF |=>
            rdata[15:0] == $past(wdata[15:0], 3);
    endproperty
    property p_irq_st;
        rd && addr == IRQ_ST_OFF && irq |=> rdata[1:0] != 2'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    a_main_rd: assert property (p_main_rd) else $error("main flag read");
    a_comb_rise: assert property (p_comb_rise) else $error("flag rise");
    a_oe: assert property (p_oe) else $error("pin enable moved");
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("ctrl readback");
    a_upper_rb: assert property (p_upper_rb) else $error("limit read");
    a_irq_st: assert property (p_irq_st) else $error("irq without status");
    c_trip: cover property ($fell(combined_overcurrent_fault_n));
    c_pin: cover property ($fell(trip_pin_oe_n[1]));
    c_irq: cover property ($rose(irq));
endmodule // occ_checker
bind dual_overcurrent_comparator occ_checker u_chk (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trip_pin_oe_n(trip_pin_oe_n),
    .combined_overcurrent_fault_n(combined_overcurrent_fault_n), .irq(irq)
);
`default_nettype wire

// >>> verif/mod_source.sv
// first-order bitstream source for the two current modulators
`timescale 1ns/1ps
`default_nettype none
module mod_source
    import occ_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [8:0] level_a,
    input  wire logic [8:0] level_b,
    output logic [NCH-1:0]  mod_bit
);
    logic [7:0] acc_a_r = 8'h00;
    logic [7:0] acc_b_r = 8'h00;
    logic [8:0] sum_a;
    logic [8:0] sum_b;
    // 256 gives all ones, 0 all zeros, 128 a mid-scale toggle
    assign sum_a = {1'b0, acc_a_r} + level_a;
    assign sum_b = {1'b0, acc_b_r} + level_b;
    // runs free, no conversion start needed
    always @(posedge clk) begin
        acc_a_r <= sum_a[7:0];
        acc_b_r <= sum_b[7:0];
        mod_bit <= {sum_b[8], sum_a[8]};
    end
endmodule // mod_source
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the dual overcurrent comparator
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import occ_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              ce = 1'b1;
    logic [8:0]        level_a = 9'h080;
    logic [8:0]        level_b = 9'h080;
    logic [NCH-1:0]    mod_bit;
    logic [DATA_W-1:0] rdata;
    logic [NCH-1:0]    pin_out;
    logic [NCH-1:0]    pin_oe_n;
    logic              comb_n;
    logic              irq;
    int                fails = 0;
    int                compares = 0;
    int                i;
    typedef struct { logic [7:0] a; logic [31:0] v; } row_type;
    row_type rows [13] = '{'{CTRL_OFF, 32'hc}, '{CFG_A_OFF, 32'h0},
        '{UPPER_A_OFF, 32'h7fff}, '{LOWER_A_OFF, 32'h8000},
        '{UPPER_B_OFF, 32'h7fff}, '{LOWER_B_OFF, 32'h8000},
        '{DETAIL_OFF, 32'hf}, '{MASK_OFF, 32'h0}, '{MAIN_OFF, 32'h1},
        '{PINCFG_OFF, 32'h0}, '{IRQ_EN_OFF, 32'h0},
        '{IRQ_ST_OFF, 32'h0}, '{8'h40, 32'h0}};
    always #25 clk = ~clk;
    mod_source u_src (.clk(clk), .level_a(level_a), .level_b(level_b),
        .mod_bit(mod_bit));
    dual_overcurrent_comparator uut (.clk(clk), .rst(rst), .ce(ce),
        .mod_bit(mod_bit), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .trip_pin_out(pin_out), .trip_pin_oe_n(pin_oe_n),
        .combined_overcurrent_fault_n(comb_n), .irq(irq));
    ////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // bounded wait for the combined flag (0) or pin b (1) to go low
    task automatic wait_lo(input int n, input bit pin_b);
        for (i = 0; i < n && (pin_b ? pin_out[1] : comb_n) !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == n) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, i, n);
            final_report();
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int r = 0; r < 13; r++)
            rd_chk(rows[r].a, rows[r].v);
        chk({28'h0, pin_oe_n, comb_n, irq}, 32'he);
        $display("test reset done");
        // full-scale positive input against a half-scale upper limit
        level_a <= 9'h100;
        wr_reg(UPPER_A_OFF, 32'h4000);
        rd_chk(UPPER_A_OFF, 32'h4000);
        wr_reg(PINCFG_OFF, 32'h1);
        wr_reg(IRQ_EN_OFF, 32'h3);
        wr_reg(CTRL_OFF, 32'hd);
        rd_chk(CTRL_OFF, 32'hd);
        wait_lo(4 * DEC_OSR + 8, 1'b0);
        rd_chk(DETAIL_OFF, 32'he);
        chk({29'h0, pin_oe_n, pin_out[0]}, 32'h4);
        chk({31'h0, irq}, 32'h1);
        rd_chk(IRQ_ST_OFF, 32'h1);
        wr_reg(IRQ_EN_OFF, 32'h2);
        #1 chk({31'h0, irq}, 32'h0);
        wr_reg(MAIN_OFF, 32'h1);
        rd_chk(MAIN_OFF, 32'h0);
        level_a <= 9'h080;
        repeat (4 * DEC_OSR) @(posedge clk);
        rd_chk(DETAIL_OFF, 32'he);
        $display("test upper trip done");
        // host disables before touching config, then clears in order
        wr_reg(CTRL_OFF, 32'hc);
        wr_reg(DETAIL_OFF, 32'h1);
        wr_reg(MAIN_OFF, 32'h1);
        rd_chk(MAIN_OFF, 32'h1);
        chk({31'h0, pin_out[0]}, 32'h1);
        wr_reg(IRQ_EN_OFF, 32'h3);
        #1 chk({31'h0, irq}, 32'h1);
        wr_reg(IRQ_CLR_OFF, 32'h3);
        #1 chk({31'h0, irq}, 32'h0);
        wr_reg(PINCFG_OFF, 32'h9);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, pin_out[0]}, 32'h0);
        // idle heartbeat: level inverts every half period
        wr_reg(PINCFG_OFF, 32'h5);
        repeat (2) @(posedge clk);
        #1 i = pin_out[0];
        repeat (PWM_HALF_CYC) @(posedge clk);
        #1 chk({31'h0, pin_out[0]}, {31'h0, ~i[0]});
        $display("test clear done");
        // masked lower trip on b still reaches its pin
        level_b <= 9'h000;
        wr_reg(LOWER_B_OFF, 32'hc000);
        wr_reg(MASK_OFF, 32'h8);
        wr_reg(PINCFG_OFF, 32'h10);
        wr_reg(CTRL_OFF, 32'he);
        wait_lo(4 * DEC_OSR + 8, 1'b1);
        rd_chk(DETAIL_OFF, 32'h7);
        chk({31'h0, comb_n}, 32'h1);
        $display("test mask done");
        // disabled limits never trip; a trip count of 1f only delays the trip on a
        wr_reg(CTRL_OFF, 32'hc);
        wr_reg(LOWER_B_OFF, 32'h8000);
        wr_reg(CFG_A_OFF, 32'h1f);
        wr_reg(DETAIL_OFF, 32'hf);
        level_a <= 9'h100;
        wr_reg(CTRL_OFF, 32'hf);
        repeat (8 * DEC_OSR) @(posedge clk);
        rd_chk(DETAIL_OFF, 32'hf);
        rd_chk(RESULT_A_OFF, 32'h7fff);
        rd_chk(RESULT_B_OFF, 32'h8000);
        wait_lo(32 * DEC_OSR, 1'b0);
        // writes while frozen are lost
        ce <= 1'b0;
        wr_reg(MASK_OFF, 32'h0);
        ce <= 1'b1;
        rd_chk(MASK_OFF, 32'h8);
        $display("test limits done");
        final_report();
    end
endmodule // tb_top
`default_nettype wire
